// file: rtl/irq_status_mask.v
// Purpose: Group-0 and group-1 interrupt status and mask logic with identification registers.
// Assumes: Event inputs are one-cycle pulses synchronous to MCLK; idle level is a pin.
// Notes: Avalon-MM slave, fixed one wait cycle on every access.
//
// Functional notes
// RULE1: Group-0 mask, zero enables, resets all ones. The code keeps bit 5 masked (G0_RSVD_MASK) even when its mask bit is zero.
// RULE2: Mask blocks interrupt only, status still sets.
// RULE3: Bit 7 sets on control zero-length receive.
// RULE4: Group-1 bit 6 always reads zero.
// RULE5: Bit 5 mirrors PIO-done flag, unwritable.
// RULE6: Bit 4 bulk receive; NAK OUT until cleared.
// RULE7: Bit 3 bulk transmit; NAK IN until cleared.
// RULE8: Bit 2 control non-setup receive; NAK OUT.
// RULE9: Bit 1 control transmit; NAK IN until cleared.
// RULE10: Bit 0 sets after 3 ms idle.
// RULE11: Write one clears bits; reset zero.
// RULE12: Unmasked group-1 status drives interrupt one.
// RULE13: Group-1 mask, zero enables source.
// RULE14: Software never clears group-1 mask bit 6.
// RULE15: Read-only revision register, writes ignored.
// RULE16: Read-only identification register, writes ignored.
// RULE17: Unmasked group-0 status drives interrupt zero.
// RULE18: Interrupts are registered OR of status and-not mask.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "irq_status_regs.vh"
module irq_status_mask #(
    parameter                 IDLE_CYCLES = (`IDLE_TIME_US * 1000) / `CLK_PERIOD_NS
)
(
    input  wire               MCLK,
    input  wire               RST,
    input  wire [9:0]         ADDRESS,
    input  wire               READ,
    input  wire               WRITE,
    input  wire [3:0]         BYTEENABLE,
    input  wire [31:0]        WRITEDATA,
    output reg  [31:0]        READDATA,
    output reg                WAITREQUEST,
    input  wire [7:0]         GROUP0_EVENT_STATUS,
    input  wire               CTRL_ZERO_LENGTH_RX,
    input  wire               CTRL_SETUP_RX,
    input  wire               CTRL_RX_DONE,
    input  wire               CTRL_TX_DONE,
    input  wire               BULK_RX_DONE,
    input  wire               BULK_TX_DONE,
    input  wire               PIO_DONE_FLAG,
    input  wire               BUS_IDLE,
    output reg                CTRL_OUT_NAK,
    output reg                CTRL_IN_NAK,
    output reg                BULK_OUT_NAK,
    output reg                BULK_IN_NAK,
    output reg                CORE_IRQ_IN0,
    output reg                CORE_IRQ_IN1
);

    reg  [7:0]                g1_status_q;
    reg  [7:0]                g1_status_d;
    reg  [7:0]                g0_mask_q;
    reg  [7:0]                g1_mask_q;
    reg                       idle_meta_q;
    reg                       idle_sync_q;
    reg                       ack_q;
    reg  [7:0]                rd_d;
    wire                      suspend_hit;
    wire                      access;
    wire                      wr_go;
    wire                      rd_go;
    wire [7:0]                index;
    wire [7:0]                set_ev;
    wire [7:0]                clr_ev;
    wire [7:0]                g1_view;

    function any_unmasked;
        input [7:0] status;
        input [7:0] mask;
        begin
            any_unmasked = |(status & ~mask);
        end
    endfunction

    function reg_hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            reg_hit = (idx == want);
        end
    endfunction

    // The first synchroniser stage feeds only the second.
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            idle_meta_q <= 1'b0;
            idle_sync_q <= 1'b0;
        end
        else
        begin
            idle_meta_q <= BUS_IDLE;
            idle_sync_q <= idle_meta_q;
        end
    end

    suspend_timer #(
        .IDLE_CYCLES (IDLE_CYCLES)
    ) u_suspend (
        .clk         (MCLK),
        .rst         (RST),
        .idle        (idle_sync_q),
        .hit         (suspend_hit)
    ); // RULE10

    assign index  = ADDRESS[9:2];
    assign access = (READ | WRITE) & ~ack_q;
    assign wr_go  = WRITE & ack_q & BYTEENABLE[0];
    assign rd_go  = READ & ~ack_q;

    // Each event input sets its status bit; the mask never enters here.
    assign set_ev[`G1_ZLP_BIT]     = CTRL_ZERO_LENGTH_RX; // RULE3 RULE2
    assign set_ev[`G1_RSVD_BIT]    = 1'b0;
    assign set_ev[`G1_PIO_BIT]     = 1'b0;
    assign set_ev[`G1_BULK_RX_BIT] = BULK_RX_DONE; // RULE6
    assign set_ev[`G1_BULK_TX_BIT] = BULK_TX_DONE; // RULE7
    assign set_ev[`G1_CTRL_RX_BIT] = CTRL_RX_DONE & ~CTRL_SETUP_RX & ~CTRL_ZERO_LENGTH_RX; // RULE8
    assign set_ev[`G1_CTRL_TX_BIT] = CTRL_TX_DONE; // RULE9
    assign set_ev[`G1_SUSPEND_BIT] = suspend_hit; // RULE10

    assign clr_ev = wr_go && reg_hit(index, `G1_STATUS_IDX) ?
                    (WRITEDATA[7:0] & `G1_W1C_BITS) : 8'h00; // RULE11

    // Set wins over a clear in the same cycle.
    always @*
    begin
        g1_status_d = ((g1_status_q & ~clr_ev) | set_ev) & `G1_W1C_BITS; // RULE11 RULE4
    end

    assign g1_view = (g1_status_q & `G1_W1C_BITS) | ({7'h00, PIO_DONE_FLAG} << `G1_PIO_BIT); // RULE5

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            g1_status_q <= `G1_STATUS_RST; // RULE11
            g0_mask_q   <= `G0_MASK_RST; // RULE1
            g1_mask_q   <= `G1_MASK_RST; // RULE13
        end
        else
        begin
            g1_status_q <= g1_status_d;
            if (wr_go && reg_hit(index, `G0_MASK_IDX))
            begin
                g0_mask_q <= WRITEDATA[7:0]; // RULE1
            end
            if (wr_go && reg_hit(index, `G1_MASK_IDX))
            begin
                g1_mask_q <= WRITEDATA[7:0]; // RULE13 RULE14
            end
        end
    end

    always @*
    begin
        rd_d = 8'h00;
        case (index)
            `G1_STATUS_IDX: rd_d = g1_view; // RULE4
            `G0_MASK_IDX:   rd_d = g0_mask_q;
            `G1_MASK_IDX:   rd_d = g1_mask_q;
            `SIL_REV_IDX:   rd_d = `SIL_REV_VALUE; // RULE15
            `CHIP_ID_IDX:   rd_d = `CHIP_ID_VALUE; // RULE16
            `G0_STATUS_IDX: rd_d = GROUP0_EVENT_STATUS;
            default:        rd_d = 8'h00;
        endcase
    end

    // Bus answer: waitrequest high in the first cycle, low in the second.
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ack_q       <= 1'b0;
            WAITREQUEST <= 1'b1;
            READDATA    <= 32'h00000000;
        end
        else
        begin
            ack_q       <= access;
            WAITREQUEST <= ~access;
            if (rd_go)
            begin
                READDATA <= {24'h000000, rd_d};
            end
        end
    end

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            CORE_IRQ_IN0 <= 1'b0;
            CORE_IRQ_IN1 <= 1'b0;
            CTRL_OUT_NAK <= 1'b0;
            CTRL_IN_NAK  <= 1'b0;
            BULK_OUT_NAK <= 1'b0;
            BULK_IN_NAK  <= 1'b0;
        end
        else
        begin
            CORE_IRQ_IN0 <= any_unmasked(GROUP0_EVENT_STATUS, g0_mask_q | ~`G0_RSVD_MASK); // RULE17 RULE18 RULE2
            CORE_IRQ_IN1 <= any_unmasked(g1_view, g1_mask_q); // RULE12 RULE18 RULE2
            CTRL_OUT_NAK <= g1_status_d[`G1_CTRL_RX_BIT]; // RULE8
            CTRL_IN_NAK  <= g1_status_d[`G1_CTRL_TX_BIT]; // RULE9
            BULK_OUT_NAK <= g1_status_d[`G1_BULK_RX_BIT]; // RULE6
            BULK_IN_NAK  <= g1_status_d[`G1_BULK_TX_BIT]; // RULE7
        end
    end

endmodule

// file: rtl/irq_status_regs.vh
// Purpose: Register map, field positions and reset values of the interrupt status block.
// Assumes: Avalon-MM byte addresses, one aligned 32-bit word per register.
// Notes: Printed offsets are register indexes; byte address is four times the index.
`ifndef IRQ_STATUS_REGS_VH
`define IRQ_STATUS_REGS_VH

`define G1_STATUS_IDX      8'h90
`define G0_MASK_IDX        8'h93
`define G1_MASK_IDX        8'h94
`define SIL_REV_IDX        8'h95
`define CHIP_ID_IDX        8'h96
`define G0_STATUS_IDX      8'h98

`define G1_STATUS_RST      8'h00
`define G0_MASK_RST        8'hff
`define G1_MASK_RST        8'hff

`define G1_ZLP_BIT         7
`define G1_RSVD_BIT        6
`define G1_PIO_BIT         5
`define G1_BULK_RX_BIT     4
`define G1_BULK_TX_BIT     3
`define G1_CTRL_RX_BIT     2
`define G1_CTRL_TX_BIT     1
`define G1_SUSPEND_BIT     0

`define G1_W1C_BITS        8'h9f
`define G0_RSVD_MASK       8'hdf

`define SIL_REV_VALUE      8'h5a
`define CHIP_ID_VALUE      8'ha5

`define IDLE_TIME_US       3000
`define CLK_PERIOD_NS      50

`endif

// file: rtl/suspend_timer.v
// Purpose: Counts consecutive idle cycles of the bus and pulses once when suspend is reached.
// Assumes: Idle level is already synchronous to MCLK.
// Notes: One pulse per idle stretch; any non-idle cycle restarts the count.
`timescale 1ns/100ps
module suspend_timer #(
    parameter                 IDLE_CYCLES = 60000
)
(
    input  wire               clk,
    input  wire               rst,
    input  wire               idle,
    output reg                hit
);

    localparam [16:0]         LAST_COUNT = IDLE_CYCLES - 1;

    reg  [16:0]               count_q;
    reg                       done_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= 17'h00000;
            done_q  <= 1'b0;
            hit     <= 1'b0;
        end
        else
        begin
            hit <= 1'b0;
            if (!idle)
            begin
                count_q <= 17'h00000;
                done_q  <= 1'b0;
            end
            else if (!done_q)
            begin
                if (count_q == LAST_COUNT)
                begin
                    hit    <= 1'b1;
                    done_q <= 1'b1;
                end
                else
                begin
                    count_q <= count_q + 17'h00001;
                end
            end
        end
    end

endmodule

// file: bench/core_irq_model.sv
// Purpose: Stands for the core's external interrupt input one.
// Assumes: Level-sensitive input sampled on MCLK.
// Notes: Records that the input was ever seen high.
`timescale 1ns/100ps
module core_irq_model
(
    input  wire  clk,
    input  wire  rst,
    input  wire  irq1,
    output logic seen1
);
    always @(posedge clk or posedge rst)
        if (rst)
            seen1 <= 1'b0;
        else
            seen1 <= seen1 | irq1;
endmodule

// file: bench/irq_status_chk.sv
// Purpose: Port assertions for the interrupt status block.
// Assumes: Event inputs are one-cycle pulses.
// Notes: Bound to every instance.
`timescale 1ns/100ps
module irq_status_chk
(
    input wire        MCLK,
    input wire        RST,
    input wire        WRITE,
    input wire [31:0] READDATA,
    input wire        WAITREQUEST,
    input wire [7:0]  GROUP0_EVENT_STATUS,
    input wire        CTRL_ZERO_LENGTH_RX,
    input wire        CTRL_SETUP_RX,
    input wire        CTRL_RX_DONE,
    input wire        CTRL_TX_DONE,
    input wire        BULK_RX_DONE,
    input wire        BULK_TX_DONE,
    input wire        CTRL_OUT_NAK,
    input wire        CTRL_IN_NAK,
    input wire        BULK_OUT_NAK,
    input wire        BULK_IN_NAK,
    input wire        CORE_IRQ_IN0,
    input wire        CORE_IRQ_IN1
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_bulk_rx_nak: assert property (BULK_RX_DONE |=> BULK_OUT_NAK)
        else $error("bulk out nak missing");
    chk_bulk_tx_nak: assert property (BULK_TX_DONE |=> BULK_IN_NAK)
        else $error("bulk in nak missing");
    chk_ctrl_tx_nak: assert property (CTRL_TX_DONE |=> CTRL_IN_NAK)
        else $error("control in nak missing");
    chk_ctrl_rx_nak: assert property (CTRL_RX_DONE && !CTRL_SETUP_RX && !CTRL_ZERO_LENGTH_RX
        |=> CTRL_OUT_NAK)
        else $error("control out nak missing");
    chk_setup_no_nak: assert property (CTRL_RX_DONE && CTRL_SETUP_RX && !CTRL_OUT_NAK
        |=> !CTRL_OUT_NAK)
        else $error("setup packet set control out nak");
    chk_nak_by_write: assert property ($fell(BULK_OUT_NAK) |-> $past(WRITE) || $past(WRITE, 2))
        else $error("bulk out nak cleared without write");
    chk_irq0_quiet: assert property ($past(GROUP0_EVENT_STATUS) == 8'h00
        && GROUP0_EVENT_STATUS == 8'h00 |=> !CORE_IRQ_IN0)
        else $error("irq0 high with no group-0 status");
    chk_upper_zero: assert property (!WAITREQUEST |-> READDATA[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    cover property ($rose(CORE_IRQ_IN1));
    cover property ($rose(CORE_IRQ_IN0));
    cover property (CTRL_RX_DONE && CTRL_SETUP_RX);
endmodule
bind irq_status_mask irq_status_chk i_chk (.MCLK, .RST, .WRITE, .READDATA, .WAITREQUEST,
    .GROUP0_EVENT_STATUS, .CTRL_ZERO_LENGTH_RX, .CTRL_SETUP_RX, .CTRL_RX_DONE, .CTRL_TX_DONE,
    .BULK_RX_DONE, .BULK_TX_DONE, .CTRL_OUT_NAK, .CTRL_IN_NAK, .BULK_OUT_NAK, .BULK_IN_NAK,
    .CORE_IRQ_IN0, .CORE_IRQ_IN1);

// file: bench/irq_status_mask_tb.sv
// Purpose: Self-checking bench for the interrupt status block.
// Assumes: One wait cycle per access.
// Notes: Idle count shortened to 20 cycles.
`timescale 1ns/100ps
module irq_status_mask_tb;
    logic mclk = 0, rst = 1, rdr = 0, wrr = 0, pio = 0, idle = 0, wt, i0, i1, seen1;
    logic [9:0] adr = 0;
    logic [31:0] wd = 0, rdata;
    logic [7:0] g0 = 0, v, r;
    logic [5:0] pl = 0;
    logic [3:0] nak;
    int mismatches = 0, checks_done = 0;
    irq_status_mask #(.IDLE_CYCLES(20)) i_dut (.MCLK(mclk), .RST(rst), .ADDRESS(adr),
        .READ(rdr), .WRITE(wrr), .BYTEENABLE(4'h1), .WRITEDATA(wd), .READDATA(rdata),
        .WAITREQUEST(wt), .GROUP0_EVENT_STATUS(g0), .CTRL_ZERO_LENGTH_RX(pl[5]),
        .CTRL_SETUP_RX(pl[4]), .CTRL_RX_DONE(pl[3]), .CTRL_TX_DONE(pl[2]),
        .BULK_RX_DONE(pl[1]), .BULK_TX_DONE(pl[0]), .PIO_DONE_FLAG(pio), .BUS_IDLE(idle),
        .CTRL_OUT_NAK(nak[3]), .CTRL_IN_NAK(nak[2]), .BULK_OUT_NAK(nak[1]),
        .BULK_IN_NAK(nak[0]), .CORE_IRQ_IN0(i0), .CORE_IRQ_IN1(i1));
    core_irq_model i_core (.clk(mclk), .rst(rst), .irq1(i1), .seen1(seen1));
    task complete_run;
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge mclk);
        rdr <= !w;
        wrr <= w;
        adr <= {idx, 2'b00};
        wd <= {24'h0, d};
        for (n = 0; n < 20; n++)
        begin
            @(posedge mclk);
            if (wt === 1'b0)
                break;
        end
        v = rdata[7:0];
        rdr <= 1'b0;
        wrr <= 1'b0;
        if (n == 20)
        begin
            mismatches++;
            complete_run;
        end
    endtask
    task pulse(input logic [5:0] p);
        @(posedge mclk);
        pl <= p;
        @(posedge mclk);
        pl <= 6'h0;
    endtask
    task t_regs;
        bus(0, 8'h90, 0); chk("g1 status", 8'h00, v);
        bus(0, 8'h93, 0); chk("g0 mask", 8'hff, v);
        bus(0, 8'h94, 0); chk("g1 mask", 8'hff, v);
        for (int a = 8'h95; a < 8'h97; a++)
        begin
            bus(0, a, 0);
            r = v;
            bus(1, a, ~r);
            bus(0, a, 0); chk("id reg", r, v);
        end
        bus(1, 8'h70, 8'h33);
        bus(0, 8'h70, 0); chk("unmapped", 8'h00, v);
    endtask
    task t_events;
        pulse(6'h18);
        bus(0, 8'h90, 0); chk("setup", 8'h00, v);
        for (int b = 0; b < 6; b++)
            pulse(6'h01 << b);
        bus(0, 8'h90, 0); chk("events", 8'h9e, v);
        chk("naks", 8'h0f, {4'h0, nak});
        chk("irq1 masked", {7'h0, i1}, 8'h00);
        bus(1, 8'h90, 8'h00);
        bus(0, 8'h90, 0); chk("write zero", 8'h9e, v);
        bus(1, 8'h94, 8'h40);
        repeat (3) @(negedge mclk);
        chk("irq1", {7'h0, i1}, 8'h01);
        chk("core seen", {7'h0, seen1}, 8'h01);
        bus(1, 8'h90, 8'h0c);
        bus(0, 8'h90, 0); chk("w1c", 8'h92, v);
        chk("naks left", 8'h06, {4'h0, nak});
        bus(1, 8'h90, 8'hff);
        repeat (3) @(negedge mclk);
        chk("irq1 off", {7'h0, i1}, 8'h00);
    endtask
    task t_pio;
        @(posedge mclk);
        pio <= 1'b1;
        bus(1, 8'h90, 8'h60);
        bus(0, 8'h90, 0); chk("pio mirror", 8'h20, v);
        chk("irq1 pio", {7'h0, i1}, 8'h01);
        bus(1, 8'h94, 8'h60);
        repeat (3) @(negedge mclk);
        chk("pio masked", {7'h0, i1}, 8'h00);
        @(posedge mclk);
        pio <= 1'b0;
    endtask
    task t_g0;
        @(posedge mclk);
        g0 <= 8'h10;
        repeat (3) @(negedge mclk);
        chk("irq0 masked", {7'h0, i0}, 8'h00);
        bus(1, 8'h93, 8'hef);
        repeat (3) @(negedge mclk);
        chk("irq0", {7'h0, i0}, 8'h01);
        bus(0, 8'h93, 0); chk("g0 mask rw", 8'hef, v);
        bus(0, 8'h98, 0); chk("g0 status view", 8'h10, v);
        @(posedge mclk);
        g0 <= 8'h00;
    endtask
    task t_susp;
        bus(1, 8'h94, 8'hfe);
        @(posedge mclk);
        idle <= 1'b1;
        repeat (40) @(negedge mclk);
        bus(0, 8'h90, 0); chk("suspend", 8'h01, v);
        chk("irq1 susp", {7'h0, i1}, 8'h01);
        bus(1, 8'h90, 8'h01);
        repeat (40) @(negedge mclk);
        bus(0, 8'h90, 0); chk("suspend once", 8'h00, v);
        @(posedge mclk);
        idle <= 1'b0;
    endtask
    initial
        forever #25 mclk = ~mclk;
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_events;
        t_pio;
        t_g0;
        t_susp;
        complete_run;
    end
endmodule
